// ---- hdl/fkm_pkg.sv ----
// Package of constants and types for the flash key and margin sequencer
package fkm_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_PINDEX = 12'h004;
  localparam logic [11:0] OFS_SECCFG = 12'h008;
  localparam logic [11:0] OFS_MARGIN = 12'h00C;
  localparam logic [11:0] OFS_WORD0 = 12'h010;
  localparam int NUM_WORDS = 6;
  // Status field positions
  localparam int BIT_CMD_COMPLETE_FLAG = 0;
  localparam int BIT_ACCESS_ERROR_FLAG = 1;
  localparam int BIT_PVIOL = 2;
  localparam int BIT_VERR = 3;
  localparam int BIT_VUNC = 4;
  // Security config field positions
  localparam int POS_BACKDOOR_KEY_ENABLE = 0;
  localparam int BIT_SECURED = 2;
  localparam int BIT_LOCKED = 3;
  // Margin field positions
  localparam int POS_PF_MARGIN = 0;
  localparam int POS_EE_MARGIN = 8;
  // Command codes
  localparam logic [7:0] CMD_VERIFY_KEY = 8'h0C;
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
  // Expected parameter index at launch
  localparam logic [2:0] PIDX_KEY = 3'h4;
  localparam logic [2:0] PIDX_MARGIN = 3'h2;
  // Backdoor enable value that allows key verification
  localparam logic [1:0] BACKDOOR_KEY_ENABLE_ON = 2'h2;
  // Margin settings
  localparam logic [15:0] MRG_NORMAL = 16'h0000;
  localparam logic [15:0] MRG_USER1 = 16'h0001;
  localparam logic [15:0] MRG_USER0 = 16'h0002;
  localparam logic [15:0] MRG_FIELD1 = 16'h0003;
  localparam logic [15:0] MRG_FIELD0 = 16'h0004;
  // Reset values
  localparam logic RST_CMD_COMPLETE_FLAG = 1'b1;
  localparam logic RST_SECURED = 1'b1;
  localparam logic [2:0] RST_MARGIN = 3'h0;
  typedef enum logic [0:0] {FKM_IDLE, FKM_EXEC} fkm_state_t;
  typedef struct packed {
    fkm_state_t state;
    logic cmd_complete_flag;
    logic access_error_flag;
    logic secured;
    logic locked;
    logic [2:0] pidx;
    logic [NUM_WORDS-1:0][15:0] words;
    logic [2:0] pf_margin;
    logic [2:0] ee_margin;
    logic [31:0] prdata;
    logic pslverr;
  } fkm_st_t;
endpackage

// ---- hdl/fkm_seq.sv ----
// Flash key verification and margin level command sequencer, APB slave
// Summary of operation
// - Command 0x0C verifies four backdoor key words
// - Key command needs parameter index 100
// - Key command needs backdoor enable equal 10
// - Key words compared in address order
// - Full key match releases security
// - Mismatch keeps security, errors until reset
// - Key command always ends with complete flag
// - Command 0x0D sets user margin level
// - Margin commands need parameter index 010
// - Margin address must hit a flash block
// - Margin command must suit operating mode
// - User margin accepts settings zero to two
// - Program block margin covers both blocks
// - Valid user margin stored, then complete
// - Command 0x0E field margin, special mode only
// - Field margin also accepts three and four
// - Field margin targeting follows block rules
// - Valid field margin stored, then complete
// - Clearing complete flag launches the command
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fkm_seq
  import fkm_pkg::*;
#(
  parameter logic [23:0] PF_LO = 24'hFC0000,
  parameter logic [23:0] PF_HI = 24'hFFFFFF,
  parameter logic [23:0] EE_LO = 24'h100000,
  parameter logic [23:0] EE_HI = 24'h1003FF
)(
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Flash configuration field and mode, same clock domain
  input wire logic [63:0] KEY_CFG,
  input wire logic [1:0] KEY_ENABLE,
  input wire logic SPECIAL_MODE,
  // Status and margin outputs
  output logic CMD_COMPLETE,
  output logic ACCESS_ERROR,
  output logic SECURED,
  output logic [2:0] PFLASH_MARGIN,
  output logic [2:0] EEPROM_MARGIN
);
  import fkm_pkg::*;

  localparam fkm_st_t RST_ST = '{
    state: FKM_IDLE, cmd_complete_flag: RST_CMD_COMPLETE_FLAG, access_error_flag: 1'b0, secured: RST_SECURED,
    locked: 1'b0, pidx: 3'h0, words: '0, pf_margin: RST_MARGIN,
    ee_margin: RST_MARGIN, prdata: 32'h0000_0000, pslverr: 1'b0};

  fkm_st_t s_ff;
  fkm_st_t nxt_s;

  function automatic logic in_pflash(input logic [23:0] a);
    in_pflash = (a >= PF_LO) && (a <= PF_HI);
  endfunction

  function automatic logic in_eeprom(input logic [23:0] a);
    in_eeprom = (a >= EE_LO) && (a <= EE_HI);
  endfunction

  // Word slot of an address, NUM_WORDS when not a word register
  function automatic int word_slot(input logic [11:0] a);
    word_slot = NUM_WORDS;
    for (int i = 0; i < NUM_WORDS; i++)
    begin
      if (a == OFS_WORD0 + 12'(4 * i))
        word_slot = i;
    end
  endfunction

  logic setup;
  logic access;
  logic wr;
  logic [7:0] cmd;
  logic [23:0] tgt;
  logic [15:0] level;
  logic key_match;
  logic level_ok;
  logic mode_ok;
  logic err;
  int slot;

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign wr = access && PWRITE;
  assign cmd = s_ff.words[0][15:8];
  assign tgt = {s_ff.words[0][7:0], s_ff.words[1]};
  assign level = s_ff.words[2];

  always_comb
  begin
    nxt_s = s_ff;
    key_match = 1'b1;
    level_ok = 1'b0;
    mode_ok = 1'b0;
    err = 1'b0;
    slot = word_slot(PADDR);
    // Key word zero against the lowest configuration word
    for (int k = 0; k < 4; k++)
    begin
      if (s_ff.words[k + 1] != KEY_CFG[16 * k +: 16])
        key_match = 1'b0;
    end
    // Read data captured in the setup phase so it leaves a flop
    if (setup)
    begin
      nxt_s.prdata = 32'h0000_0000;
      nxt_s.pslverr = 1'b0;
      if (PADDR == OFS_STATUS)
      begin
        nxt_s.prdata[BIT_CMD_COMPLETE_FLAG] = s_ff.cmd_complete_flag;
        nxt_s.prdata[BIT_ACCESS_ERROR_FLAG] = s_ff.access_error_flag;
        nxt_s.prdata[BIT_PVIOL] = 1'b0;
        nxt_s.prdata[BIT_VERR] = 1'b0;
        nxt_s.prdata[BIT_VUNC] = 1'b0;
      end
      else if (PADDR == OFS_PINDEX)
        nxt_s.prdata[2:0] = s_ff.pidx;
      else if (PADDR == OFS_SECCFG)
      begin
        nxt_s.prdata[POS_BACKDOOR_KEY_ENABLE +: 2] = KEY_ENABLE;
        nxt_s.prdata[BIT_SECURED] = s_ff.secured;
        nxt_s.prdata[BIT_LOCKED] = s_ff.locked;
      end
      else if (PADDR == OFS_MARGIN)
      begin
        nxt_s.prdata[POS_PF_MARGIN +: 3] = s_ff.pf_margin;
        nxt_s.prdata[POS_EE_MARGIN +: 3] = s_ff.ee_margin;
      end
      else if (slot < NUM_WORDS)
        nxt_s.prdata[15:0] = s_ff.words[slot];
      else
        nxt_s.pslverr = 1'b1;
    end
    // Writes; parameter words and index stay frozen while busy
    if (wr && s_ff.state == FKM_IDLE && s_ff.cmd_complete_flag)
    begin
      if (PADDR == OFS_PINDEX)
        nxt_s.pidx = PWDATA[2:0];
      else if (slot < NUM_WORDS)
        nxt_s.words[slot] = PWDATA[15:0];
    end
    if (wr && PADDR == OFS_STATUS)
    begin
      if (PWDATA[BIT_ACCESS_ERROR_FLAG])
        nxt_s.access_error_flag = 1'b0;
      // Writing one to the complete flag clears it and launches
      if (PWDATA[BIT_CMD_COMPLETE_FLAG] && s_ff.cmd_complete_flag)
      begin
        nxt_s.cmd_complete_flag = 1'b0;
        nxt_s.access_error_flag = 1'b0;
        nxt_s.state = FKM_EXEC;
      end
    end
    if (s_ff.state == FKM_EXEC)
    begin
      unique case (cmd)
        CMD_VERIFY_KEY:
        begin
          if (s_ff.pidx != PIDX_KEY)
            err = 1'b1;
          else if (KEY_ENABLE != BACKDOOR_KEY_ENABLE_ON)
            err = 1'b1;
          else if (s_ff.locked)
            err = 1'b1;
          else if (key_match)
            nxt_s.secured = 1'b0;
          else
          begin
            nxt_s.locked = 1'b1;
            err = 1'b1;
          end
        end
        CMD_USER_MARGIN, CMD_FIELD_MARGIN:
        begin
          // User margin runs in every mode, field margin needs special
          mode_ok = (cmd == CMD_USER_MARGIN) || SPECIAL_MODE;
          level_ok = (level == MRG_NORMAL) || (level == MRG_USER1) ||
                     (level == MRG_USER0);
          if (cmd == CMD_FIELD_MARGIN && (level == MRG_FIELD1 ||
              level == MRG_FIELD0))
            level_ok = 1'b1;
          if (s_ff.pidx != PIDX_MARGIN)
            err = 1'b1;
          else if (!in_pflash(tgt) && !in_eeprom(tgt))
            err = 1'b1;
          else if (!mode_ok)
            err = 1'b1;
          else if (!level_ok)
            err = 1'b1;
          else
          begin
            // No separate program-only level exists
            nxt_s.ee_margin = level[2:0];
            if (in_pflash(tgt))
              nxt_s.pf_margin = level[2:0];
          end
        end
        default:
          err = 1'b1;
      endcase
      // A software clear in this cycle loses only to a new error
      nxt_s.access_error_flag = nxt_s.access_error_flag | err;
      nxt_s.cmd_complete_flag = 1'b1;
      nxt_s.state = FKM_IDLE;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      s_ff <= RST_ST;
    else
      s_ff <= nxt_s;
  end

  // Zero wait states: answer on the first access cycle
  assign PREADY = access;
  assign PRDATA = s_ff.prdata;
  assign PSLVERR = s_ff.pslverr && access;
  assign CMD_COMPLETE = s_ff.cmd_complete_flag;
  assign ACCESS_ERROR = s_ff.access_error_flag;
  assign SECURED = s_ff.secured;
  assign PFLASH_MARGIN = s_ff.pf_margin;
  assign EEPROM_MARGIN = s_ff.ee_margin;

  logic launch;
  logic is_key;
  logic is_mrg;
  assign launch = wr && PADDR == OFS_STATUS && PWDATA[BIT_CMD_COMPLETE_FLAG] && s_ff.cmd_complete_flag;
  assign is_key = s_ff.state == FKM_EXEC && cmd == CMD_VERIFY_KEY;
  assign is_mrg = s_ff.state == FKM_EXEC &&
                  (cmd == CMD_USER_MARGIN || cmd == CMD_FIELD_MARGIN);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_launch_busy: assert property (launch |=>
    !CMD_COMPLETE ##1 CMD_COMPLETE)
    else $error("Launch did not give one busy cycle");
  a_key_index: assert property (is_key && s_ff.pidx != PIDX_KEY |=>
    ACCESS_ERROR && SECURED == $past(SECURED))
    else $error("Bad key index not refused");
  a_key_enable: assert property (is_key && KEY_ENABLE != BACKDOOR_KEY_ENABLE_ON |=>
    ACCESS_ERROR && SECURED == $past(SECURED))
    else $error("Disabled key command not refused");
  a_key_release: assert property (is_key && s_ff.pidx == PIDX_KEY &&
    KEY_ENABLE == BACKDOOR_KEY_ENABLE_ON && !s_ff.locked && key_match |=>
    !SECURED && !ACCESS_ERROR)
    else $error("Matching key did not unsecure");
  a_key_lock: assert property (is_key && s_ff.pidx == PIDX_KEY &&
    KEY_ENABLE == BACKDOOR_KEY_ENABLE_ON && !key_match |=>
    s_ff.locked && ACCESS_ERROR && SECURED == $past(SECURED))
    else $error("Mismatch did not lock out");
  a_lock_sticky: assert property (s_ff.locked |=> s_ff.locked)
    else $error("Lockout cleared without reset");
  a_exec_done: assert property (s_ff.state == FKM_EXEC |=> CMD_COMPLETE)
    else $error("Command did not complete");
  a_mrg_index: assert property (is_mrg && s_ff.pidx != PIDX_MARGIN |=>
    ACCESS_ERROR && $stable(EEPROM_MARGIN))
    else $error("Bad margin index not refused");
  a_mrg_addr: assert property (is_mrg && !in_pflash(tgt) &&
    !in_eeprom(tgt) |=> ACCESS_ERROR && $stable(PFLASH_MARGIN))
    else $error("Bad margin address not refused");
  a_field_mode: assert property (is_mrg && cmd == CMD_FIELD_MARGIN &&
    !SPECIAL_MODE |=> ACCESS_ERROR && $stable(EEPROM_MARGIN))
    else $error("Field margin ran in normal mode");
  a_mrg_level: assert property (is_mrg && !err |=>
    EEPROM_MARGIN <= 3'(cmd == CMD_USER_MARGIN ? 2 : 4))
    else $error("Illegal margin level stored");
  a_pf_both: assert property (is_mrg && !err && in_pflash(tgt) |=>
    PFLASH_MARGIN == EEPROM_MARGIN && PFLASH_MARGIN == $past(level[2:0]))
    else $error("Program block margin not applied to both");
  a_ee_only: assert property (is_mrg && !err && in_eeprom(tgt) &&
    !in_pflash(tgt) |=> $stable(PFLASH_MARGIN))
    else $error("Second block margin touched program block");
  a_set_wins: assert property (s_ff.state == FKM_EXEC && err |=>
    ACCESS_ERROR)
    else $error("Error lost against clear");

  // Launch and busy phase
  a_launch_clear: assert property (launch |=>
    !ACCESS_ERROR && s_ff.state == FKM_EXEC)
    else $error("Launch did not clear error and start");
  a_exec_single: assert property (s_ff.state == FKM_EXEC |=>
    s_ff.state == FKM_IDLE)
    else $error("Command ran longer than one cycle");
  // Software may poll while busy, so loaded words must not move
  a_busy_frozen: assert property (!s_ff.cmd_complete_flag |=>
    $stable(s_ff.words) && $stable(s_ff.pidx))
    else $error("Parameters changed while busy");
  a_idle_hold: assert property (s_ff.state == FKM_IDLE |=>
    $stable(SECURED) && $stable(PFLASH_MARGIN) && $stable(EEPROM_MARGIN))
    else $error("State changed without a command");
  a_complete_rise: assert property ($rose(CMD_COMPLETE) |->
    $past(s_ff.state == FKM_EXEC))
    else $error("Complete flag rose outside a command");
  a_unknown_cmd: assert property (s_ff.state == FKM_EXEC &&
    !is_key && !is_mrg |=> ACCESS_ERROR)
    else $error("Unknown command not refused");

  // Backdoor key command
  a_key_locked: assert property (is_key && s_ff.locked |=>
    ACCESS_ERROR && SECURED == $past(SECURED))
    else $error("Locked key command not refused");
  a_key_resolve: assert property (is_key && s_ff.pidx == PIDX_KEY &&
    KEY_ENABLE == BACKDOOR_KEY_ENABLE_ON |=> !SECURED || s_ff.locked)
    else $error("Enabled key command left no result");
  a_key_clean: assert property (is_key && !err |=>
    !ACCESS_ERROR && !SECURED)
    else $error("Accepted key command reported an error");
  // Security only drops through a matching key, never by a side path
  a_sec_only_key: assert property (SECURED && !is_key |=> SECURED)
    else $error("Security released outside key command");
  a_seccfg_lock: assert property (setup && PADDR == OFS_SECCFG |=>
    PRDATA[BIT_LOCKED] == $past(s_ff.locked))
    else $error("Lockout state not readable");

  // Margin commands
  a_mrg_clean: assert property (is_mrg && !err |=>
    !ACCESS_ERROR)
    else $error("Accepted margin command raised an error");
  a_mrg_store: assert property (is_mrg && !err |=>
    EEPROM_MARGIN == $past(level[2:0]))
    else $error("Accepted margin level not stored");
  a_user_field: assert property (is_mrg && cmd == CMD_USER_MARGIN &&
    level > MRG_USER0 |=> ACCESS_ERROR && $stable(EEPROM_MARGIN))
    else $error("User margin took a field level");
  a_level_range: assert property (is_mrg && level > MRG_FIELD0 |=>
    ACCESS_ERROR && $stable(PFLASH_MARGIN) && $stable(EEPROM_MARGIN))
    else $error("Out of range margin level accepted");
  a_user_mode: assert property (is_mrg && cmd == CMD_USER_MARGIN &&
    s_ff.pidx == PIDX_MARGIN && (in_pflash(tgt) || in_eeprom(tgt)) &&
    level <= MRG_USER0 |=> !ACCESS_ERROR)
    else $error("Valid user margin refused");
  a_field_ok: assert property (is_mrg && cmd == CMD_FIELD_MARGIN &&
    SPECIAL_MODE && s_ff.pidx == PIDX_MARGIN &&
    (in_pflash(tgt) || in_eeprom(tgt)) && level <= MRG_FIELD0 |=>
    !ACCESS_ERROR)
    else $error("Valid field margin refused");

  // Register read side
  a_status_read: assert property (setup && PADDR == OFS_STATUS |=>
    PRDATA[BIT_CMD_COMPLETE_FLAG] == $past(CMD_COMPLETE))
    else $error("Complete flag not readable");
  a_status_zero: assert property (setup && PADDR == OFS_STATUS |=>
    PRDATA[BIT_VUNC:BIT_PVIOL] == 3'h0)
    else $error("Unused status flags read as set");
  a_pindex_read: assert property (setup && PADDR == OFS_PINDEX |=>
    PRDATA[2:0] == $past(s_ff.pidx))
    else $error("Parameter index not readable");

  c_unlock: cover property (is_key ##1 !SECURED);
  c_lockout: cover property (is_key && !key_match ##1 s_ff.locked);
  c_user_mrg: cover property (is_mrg && !err && cmd == CMD_USER_MARGIN);
  c_field_mrg: cover property (is_mrg && !err && cmd == CMD_FIELD_MARGIN);
  c_field_refused: cover property (is_mrg && cmd == CMD_FIELD_MARGIN &&
    !SPECIAL_MODE);
endmodule
`default_nettype wire

// ---- verification/fkm_seq_tb_top.sv ----
// Self-checking bench for the flash key and margin sequencer
`timescale 1ns/1ps
`default_nettype none
module fkm_seq_tb_top;
  import fkm_pkg::*;
  localparam logic [23:0] PF_ADR = 24'hFC0000;
  localparam logic [23:0] EE_ADR = 24'h100000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Key words differ so that a swapped compare order is caught
  logic [63:0] key_cfg = 64'h4444_3333_2222_1111;
  logic [1:0] key_en = BACKDOOR_KEY_ENABLE_ON;
  logic spec = 1'b0;
  logic cmd_complete;
  logic access_error;
  logic secured;
  logic [2:0] pfm;
  logic [2:0] eem;
  logic [31:0] rd;
  logic slv;
  logic exp_sec;
  logic [2:0] exp_pf;
  logic [2:0] exp_ee;
  int err_total = 0;
  int n_tests = 0;

  fkm_seq u_dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .KEY_CFG(key_cfg),
    .KEY_ENABLE(key_en), .SPECIAL_MODE(spec), .CMD_COMPLETE(cmd_complete),
    .ACCESS_ERROR(access_error), .SECURED(secured), .PFLASH_MARGIN(pfm),
    .EEPROM_MARGIN(eem));

  always #10 clk = ~clk;

  task stop_test;
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask

  // One APB transfer; waits on pready with a bound, never a fixed count
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 10; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 10)
    begin
      err_total++;
      stop_test();
    end
  endtask

  task do_rst;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    exp_sec = 1'b1;
    exp_pf = 3'h0;
    exp_ee = 3'h0;
  endtask

  // Loads words 0..4 and the index, launches, waits for completion
  task cmd(input logic [7:0] op, input logic [23:0] adr,
    input logic [15:0] w2, input logic [15:0] w3, input logic [15:0] w4,
    input logic [2:0] idx);
    int i;
    logic seen0;
    apb(1'b1, OFS_WORD0, {16'h0, op, adr[23:16]});
    apb(1'b1, OFS_WORD0 + 12'h004, {16'h0, adr[15:0]});
    apb(1'b1, OFS_WORD0 + 12'h008, {16'h0, w2});
    apb(1'b1, OFS_WORD0 + 12'h00C, {16'h0, w3});
    apb(1'b1, OFS_WORD0 + 12'h010, {16'h0, w4});
    apb(1'b1, OFS_PINDEX, {29'h0, idx});
    apb(1'b1, OFS_STATUS, 32'h0000_0001);
    seen0 = 1'b0;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (cmd_complete === 1'b0)
        seen0 = 1'b1;
      else if (seen0 && cmd_complete === 1'b1)
        break;
    end
    if (i == 20)
    begin
      err_total++;
      stop_test();
    end
    chk("complete drop", 32'h1, {31'h0, seen0});
    chk("complete", 32'h1, {31'h0, cmd_complete});
  endtask

  task outcome(input logic err);
    chk("access error", {31'h0, err}, {31'h0, access_error});
    chk("secured", {31'h0, exp_sec}, {31'h0, secured});
    chk("pflash margin", {29'h0, exp_pf}, {29'h0, pfm});
    chk("eeprom margin", {29'h0, exp_ee}, {29'h0, eem});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", {30'h0, err, 1'b1}, rd);
    apb(1'b0, OFS_MARGIN, 32'h0);
    chk("margin reg", {21'h0, exp_ee, 5'h0, exp_pf}, rd);
  endtask

  task t_reset;
    outcome(1'b0);
    apb(1'b0, OFS_SECCFG, 32'h0);
    chk("seccfg", {28'h0, 2'b01, BACKDOOR_KEY_ENABLE_ON}, rd);
    apb(1'b1, 12'h028, 32'hFFFF_FFFF);
    apb(1'b0, 12'h028, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, {31'h0, slv});
  endtask

  task t_user;
    for (int lv = 0; lv < 4; lv++)
    begin
      cmd(CMD_USER_MARGIN, EE_ADR, 16'(lv), 16'h0, 16'h0, PIDX_MARGIN);
      if (lv < 3)
        exp_ee = 3'(lv);
      outcome(lv == 3);
    end
    cmd(CMD_USER_MARGIN, PF_ADR, MRG_USER0, 16'h0, 16'h0, PIDX_MARGIN);
    exp_pf = 3'h2;
    exp_ee = 3'h2;
    outcome(1'b0);
    cmd(CMD_USER_MARGIN, PF_ADR, MRG_NORMAL, 16'h0, 16'h0, PIDX_KEY);
    outcome(1'b1);
    cmd(CMD_USER_MARGIN, 24'h200000, MRG_NORMAL, 16'h0, 16'h0, PIDX_MARGIN);
    outcome(1'b1);
    cmd(8'h0B, PF_ADR, MRG_NORMAL, 16'h0, 16'h0, PIDX_MARGIN);
    outcome(1'b1);
    // Writing one to the error bit alone clears it and launches nothing
    apb(1'b1, OFS_STATUS, 32'h0000_0002);
    @(posedge clk);
    outcome(1'b0);
  endtask

  task t_field;
    cmd(CMD_FIELD_MARGIN, PF_ADR, MRG_FIELD1, 16'h0, 16'h0, PIDX_MARGIN);
    outcome(1'b1);
    @(posedge clk);
    spec <= 1'b1;
    for (int lv = 0; lv < 6; lv++)
    begin
      cmd(CMD_FIELD_MARGIN, PF_ADR, 16'(lv), 16'h0, 16'h0, PIDX_MARGIN);
      if (lv < 5)
      begin
        exp_pf = 3'(lv);
        exp_ee = 3'(lv);
      end
      outcome(lv == 5);
    end
    cmd(CMD_FIELD_MARGIN, EE_ADR, MRG_FIELD1, 16'h0, 16'h0, PIDX_MARGIN);
    exp_ee = 3'h3;
    outcome(1'b0);
    @(posedge clk);
    spec <= 1'b0;
  endtask

  task t_key;
    @(posedge clk);
    key_en <= 2'b01;
    cmd(CMD_VERIFY_KEY, 24'h1111, 16'h2222, 16'h3333, 16'h4444, PIDX_KEY);
    outcome(1'b1);
    @(posedge clk);
    key_en <= BACKDOOR_KEY_ENABLE_ON;
    cmd(CMD_VERIFY_KEY, 24'h1111, 16'h2222, 16'h3333, 16'h4444, PIDX_MARGIN);
    outcome(1'b1);
    cmd(CMD_VERIFY_KEY, 24'h1111, 16'h2222, 16'h3333, 16'h4444, PIDX_KEY);
    exp_sec = 1'b0;
    outcome(1'b0);
    do_rst();
    // Key 0 and key 1 swapped: the in-order compare must reject this and lock out
    cmd(CMD_VERIFY_KEY, 24'h2222, 16'h1111, 16'h3333, 16'h4444, PIDX_KEY);
    outcome(1'b1);
    apb(1'b0, OFS_SECCFG, 32'h0);
    chk("seccfg", {28'h0, 2'b11, BACKDOOR_KEY_ENABLE_ON}, rd);
    cmd(CMD_VERIFY_KEY, 24'h1111, 16'h2222, 16'h3333, 16'h4444, PIDX_KEY);
    outcome(1'b1);
    do_rst();
    cmd(CMD_VERIFY_KEY, 24'h1111, 16'h2222, 16'h3333, 16'h4444, PIDX_KEY);
    exp_sec = 1'b0;
    outcome(1'b0);
  endtask

  initial
  begin
    do_rst();
    t_reset();
    t_user();
    t_field();
    t_key();
    stop_test();
  end
endmodule
`default_nettype wire
